// file: design/port_irq_pkg.sv
// Constants, field positions and mode codes for the I/O port with pin interrupts
package port_irq_pkg;

    // Data-memory locations of the port registers
    localparam logic [7:0] ADDR_PORT_PIN_STATE = 8'h05; // Port pin state
    localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h0b; // Interrupt control, low bank
    localparam logic [7:0] ADDR_IRQ_CONTROL_HI = 8'h8b; // Interrupt control, mirror
    localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h85; // Direction register

    // Interrupt control field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int EDGE_PIN_IRQ_ENABLE_BIT = 4;
    localparam int PIN_CHANGE_IRQ_ENABLE_BIT = 3;
    localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
    localparam int EDGE_PIN_IRQ_FLAG_BIT = 1;
    localparam int PIN_CHANGE_FLAG_BIT = 0;

    // Pin positions with special roles
    localparam int INPUT_ONLY_PIN3 = 3; // Input only, shares the master clear
    localparam int EDGE_PIN = 2; // External edge interrupt pin
    localparam int CLOCK_OUT_PIN = 4; // Clock out / oscillator pin
    localparam int OSC_IN_PIN = 5; // Oscillator input pin

    // Reset values and fixed masks
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00; // All enables and flags clear
    localparam logic [5:0] DIRECTION_RESET = 6'h3f; // Every pin an input
    localparam logic [7:0] OUT_LATCH_RESET = 8'h00; // Output latches
    localparam logic [7:0] ANALOG_POR_MASK = 8'h17; // Pins 0, 1, 2 and 4 analog
    localparam logic [7:0] PIN_CHANGE_GROUP = 8'h0b; // Pins 0, 1 and 3
    localparam logic [7:0] GP_PIN_MASK = 8'h3f; // General-purpose pins 5..0
    localparam logic [7:0] OSC_BOTH_MASK = 8'h30; // Crystal modes own pins 4, 5
    localparam logic [7:0] OSC_IN_MASK = 8'h20; // External RC owns pin 5
    localparam logic [7:0] CLOCK_OUT_MASK = 8'h10; // Clock out owns pin 4
    localparam logic [7:0] BYTE_ZERO = 8'h00; // Unmapped read value

    // Oscillator mode taken from the configuration word
    typedef enum logic [2:0] {
        osc_lp = 3'b000,
        osc_xt = 3'b001,
        osc_hs = 3'b010,
        internal_rc_osc_mode = 3'b100,
        external_rc_osc_mode = 3'b101
    } osc_mode_t;

endpackage : port_irq_pkg

// file: design/port_with_pin_interrupts.sv
// General-purpose I/O port with direction, pin read-back and interrupt control
`timescale 1ns/1ps
module port_with_pin_interrupts
    import port_irq_pkg::*;
(
    input wire logic ref_clk, // Core clock, 125 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic power_on_reset, // Reset came from power-up, with reset
    input wire logic [7:0] reg_addr, // Data-memory address from the core
    input wire logic reg_wr_en, // Core write strobe
    input wire logic [7:0] reg_wr_data, // Core write data
    input wire logic reg_rd_en, // Core read strobe
    output logic [7:0] reg_rd_data, // Read data, one cycle after the strobe
    input wire logic [7:0] pin_in, // Pin levels from the pads
    output logic [7:0] pin_out, // Pin drive levels
    output logic [7:0] pin_oe_n, // Output enable, low while driving
    output logic [7:0] pin_pullup, // Weak pull-up enables
    input wire osc_mode_t osc_mode, // Oscillator mode from configuration word
    input wire logic clock_out_function, // Pin 4 carries the clock out
    input wire logic clock_out_level, // Clock level to put on pin 4
    input wire logic master_clear_input, // Pin 3 is the master clear input
    input wire logic [7:0] alt_func_mask, // Pins given to other functions
    input wire logic analog_cfg_wr, // Analog selection update strobe
    input wire logic [7:0] analog_cfg, // New analog pin selection
    input wire logic pullup_enable_n, // Group pull-up enable, active low
    input wire logic edge_rising, // Edge pin interrupt polarity
    input wire logic timer_overflow, // Timer overflow pulse
    input wire logic peripheral_irq, // Enabled peripheral request pending
    output logic irq_request // Interrupt request to the core
);

    // Register state
    logic [7:0] irq_control_q; // Enables and flags
    logic [5:0] direction_q; // Direction bits for pins 5..0
    logic [7:0] out_latch_q; // Output data latches
    logic [7:0] analog_q; // Pins in analog mode
    logic [7:0] change_ref_q; // Pin levels seen at the last port read
    logic [7:0] rd_data_q; // Registered read data

    // Pin synchronisers and edge history
    logic [7:0] pin_meta_q; // First stage, read by the second only
    logic [7:0] pin_sync_q; // Second stage, safe to use
    logic edge_prev_q; // Previous level of the edge pin

    // Decoded accesses and derived masks
    logic wr_port; // Write to the port register
    logic wr_dir; // Write to the direction register
    logic wr_irq; // Write to interrupt control
    logic rd_port; // Read of the port register
    logic rc_mode; // One of the two RC oscillator modes
    logic [7:0] osc_owned; // Pins taken by the oscillator
    logic [7:0] read_zero; // Pins that read as zero
    logic [7:0] dir_view; // Direction as software sees it
    logic [7:0] port_view; // Port value as software sees it
    logic [7:0] change_group; // Pins that take part in pin change
    logic edge_event; // Selected edge seen on the edge pin
    logic change_event; // Mismatch on the pin change group
    logic [2:0] flag_set; // Hardware set terms for the flags

    // True when the address hits either copy of interrupt control
    function automatic logic is_irq_addr(input logic [7:0] a);
        is_irq_addr = (a == ADDR_IRQ_CONTROL) || (a == ADDR_IRQ_CONTROL_HI);
    endfunction : is_irq_addr

    // Address decode
    assign wr_port = reg_wr_en && (reg_addr == ADDR_PORT_PIN_STATE);
    assign wr_dir = reg_wr_en && (reg_addr == ADDR_PORT_DIRECTION);
    assign wr_irq = reg_wr_en && is_irq_addr(reg_addr);
    assign rd_port = reg_rd_en && (reg_addr == ADDR_PORT_PIN_STATE);

    // Oscillator ownership of pins 4 and 5
    always_comb
    begin
        rc_mode = 1'b0;
        osc_owned = BYTE_ZERO;
        unique case (osc_mode)
            osc_lp, osc_xt, osc_hs: osc_owned = OSC_BOTH_MASK;
            external_rc_osc_mode:
            begin
                rc_mode = 1'b1;
                osc_owned = OSC_IN_MASK;
            end
            internal_rc_osc_mode: rc_mode = 1'b1;
            default: osc_owned = OSC_BOTH_MASK; // Illegal code: keep pads safe
        endcase
        if (clock_out_function)
        begin
            osc_owned = osc_owned | CLOCK_OUT_MASK;
        end
    end

    // Pins that read as zero: alternate functions, analog, oscillator, clear
    always_comb
    begin
        read_zero = (alt_func_mask | analog_q | osc_owned) & GP_PIN_MASK;
        if (master_clear_input)
        begin
            read_zero[INPUT_ONLY_PIN3] = 1'b1;
        end
    end

    // Port read reflects the pins, whatever the direction
    assign port_view = pin_sync_q & ~read_zero;

    // Direction as read back: pin 3 fixed at one, bits 7:6 fixed at zero
    always_comb
    begin
        dir_view = {2'b00, direction_q};
        dir_view[INPUT_ONLY_PIN3] = 1'b1;
        if (!rc_mode)
        begin
            dir_view[OSC_IN_PIN] = 1'b1; // Forced to input outside RC modes
            dir_view[CLOCK_OUT_PIN] = 1'b1;
        end
    end

    // Pin change participants; master clear drops pin 3 from the group
    always_comb
    begin
        change_group = PIN_CHANGE_GROUP & ~read_zero;
        if (master_clear_input)
        begin
            change_group[INPUT_ONLY_PIN3] = 1'b0;
        end
    end

    // Event detection
    assign edge_event = edge_rising ? (pin_sync_q[EDGE_PIN] && !edge_prev_q)
                                    : (!pin_sync_q[EDGE_PIN] && edge_prev_q);
    assign change_event = irq_control_q[PIN_CHANGE_IRQ_ENABLE_BIT]
                        && |((pin_sync_q ^ change_ref_q) & change_group);
    assign flag_set = {timer_overflow, edge_event, change_event};

    // Two-flop synchroniser, free-running so no false edge follows reset
    always_ff @(posedge ref_clk)
    begin
        pin_meta_q <= pin_in;
        pin_sync_q <= pin_meta_q;
        edge_prev_q <= pin_sync_q[EDGE_PIN];
    end

    // Interrupt control: software writes, hardware sets win over clears
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            irq_control_q <= IRQ_CONTROL_RESET;
        end
        else
        begin
            irq_control_q <= (wr_irq ? reg_wr_data : irq_control_q)
                | {5'b00000, flag_set};
        end
    end

    // Direction register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            direction_q <= DIRECTION_RESET;
        end
        else if (wr_dir)
        begin
            direction_q[3:0] <= reg_wr_data[3:0];
            direction_q[INPUT_ONLY_PIN3] <= 1'b1;
            if (rc_mode)
            begin
                direction_q[OSC_IN_PIN] <= reg_wr_data[OSC_IN_PIN];
                if (!clock_out_function)
                begin
                    direction_q[CLOCK_OUT_PIN] <= reg_wr_data[CLOCK_OUT_PIN];
                end
            end
        end
    end

    // Output latches hold until rewritten
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            out_latch_q <= OUT_LATCH_RESET;
        end
        else if (wr_port)
        begin
            out_latch_q <= reg_wr_data;
        end
    end

    // Analog selection: power-up makes pins analog until reconfigured
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            analog_q <= power_on_reset ? ANALOG_POR_MASK : analog_q;
        end
        else if (analog_cfg_wr)
        begin
            analog_q <= analog_cfg & ANALOG_POR_MASK;
        end
    end

    // Reference for pin change, caught at each port read
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            change_ref_q <= BYTE_ZERO;
        end
        else if (rd_port)
        begin
            change_ref_q <= pin_sync_q;
        end
    end

    // Registered read data; unmapped locations answer zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rd_data_q <= BYTE_ZERO;
        end
        else if (reg_rd_en)
        begin
            rd_data_q <= BYTE_ZERO; // Unmapped locations answer zero
            if (reg_addr == ADDR_PORT_PIN_STATE)
            begin
                rd_data_q <= port_view;
            end
            else if (reg_addr == ADDR_PORT_DIRECTION)
            begin
                rd_data_q <= dir_view;
            end
            else if (is_irq_addr(reg_addr))
            begin
                rd_data_q <= irq_control_q;
            end
        end
    end
    assign reg_rd_data = rd_data_q;

    // Pad drive: direction one floats, zero drives the latch
    always_comb
    begin
        pin_out = out_latch_q;
        pin_oe_n = dir_view | (osc_owned & ~CLOCK_OUT_MASK);
        pin_oe_n = pin_oe_n | (analog_q | alt_func_mask) & GP_PIN_MASK;
        if (clock_out_function)
        begin
            pin_out[CLOCK_OUT_PIN] = clock_out_level;
            pin_oe_n[CLOCK_OUT_PIN] = 1'b0;
        end
    end

    // Weak pull-ups switched for the group, always on for master clear
    always_comb
    begin
        pin_pullup = pullup_enable_n ? BYTE_ZERO : (PIN_CHANGE_GROUP & ~read_zero);
        if (master_clear_input)
        begin
            pin_pullup[INPUT_ONLY_PIN3] = 1'b1;
        end
    end

    // Request to the core
    always_comb
    begin
        irq_request = irq_control_q[GLOBAL_IRQ_ENABLE_BIT]
            && ((|(irq_control_q[5:3] & irq_control_q[2:0]))
            || (irq_control_q[PERIPHERAL_IRQ_ENABLE_BIT] && peripheral_irq));
    end

    // Pin change flag stays set unless software writes interrupt control
    property p_flag_sticky;
        @(posedge ref_clk) disable iff (reset)
        ($past(irq_control_q[0]) && !$past(wr_irq)) |-> irq_control_q[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    // Timer overflow sets its flag even with enables off
    property p_timer_flag;
        @(posedge ref_clk) disable iff (reset)
        timer_overflow |=> irq_control_q[TIMER_OVERFLOW_FLAG_BIT];
    endproperty
    a_timer_flag: assert property (p_timer_flag) else $error("timer flag missed");

    // No request while the global enable is clear
    property p_global_block;
        @(posedge ref_clk) disable iff (reset)
        !irq_control_q[GLOBAL_IRQ_ENABLE_BIT] |-> !irq_request;
    endproperty
    a_global_block: assert property (p_global_block) else $error("request leaked");

    // Peripheral request needs its enable
    property p_peripheral_gate;
        @(posedge ref_clk) disable iff (reset)
        (peripheral_irq && !irq_control_q[PERIPHERAL_IRQ_ENABLE_BIT]
            && ~|(irq_control_q[5:3] & irq_control_q[2:0])) |-> !irq_request;
    endproperty
    a_peripheral_gate: assert property (p_peripheral_gate) else $error("peripheral leak");

    // Direction register holds all ones after reset
    property p_dir_reset;
        @(posedge ref_clk)
        $past(reset) |-> (direction_q == DIRECTION_RESET);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong");

    // Direction read returns one on bit 3 and zero on bits 7:6
    property p_dir_read;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd_en && reg_addr == ADDR_PORT_DIRECTION)
            |=> (rd_data_q[3] && rd_data_q[7:6] == 2'b00);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

    // Direction 5:4 unchanged outside the RC modes
    property p_dir_locked;
        @(posedge ref_clk) disable iff (reset)
        !rc_mode |=> $stable(direction_q[5:4]);
    endproperty
    a_dir_locked: assert property (p_dir_locked) else $error("direction 5:4 moved");

    // Port read of a zero-reading pin is zero, others follow the pin
    property p_port_read;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd_en && reg_addr == ADDR_PORT_PIN_STATE)
            |=> (rd_data_q == ($past(pin_sync_q) & ~$past(read_zero)));
    endproperty
    a_port_read: assert property (p_port_read) else $error("port read wrong");

    // Driven pin 0 follows its latch
    property p_drive;
        @(posedge ref_clk) disable iff (reset)
        (!dir_view[0] && !read_zero[0]) |-> (!pin_oe_n[0] && pin_out[0] == out_latch_q[0]);
    endproperty
    a_drive: assert property (p_drive) else $error("pin 0 not driven");

    // Pin change mismatch sets the flag next cycle
    property p_change_flag;
        @(posedge ref_clk) disable iff (reset)
        change_event |=> irq_control_q[PIN_CHANGE_FLAG_BIT];
    endproperty
    a_change_flag: assert property (p_change_flag) else $error("change flag missed");

endmodule : port_with_pin_interrupts

// file: verif/port_pin_partner.sv
// Pin-side model: external drivers, weak pull-ups and floating pins
`timescale 1ns/1ps
module port_pin_partner (
    input wire logic ref_clk, // Core clock, wiggles floating pins
    input wire logic [7:0] pin_out, // Device drive levels
    input wire logic [7:0] pin_oe_n, // Device output enable, low drives
    input wire logic [7:0] pin_pullup, // Device weak pull-ups
    input wire logic [7:0] ext_en, // External circuit holds the pin
    input wire logic [7:0] ext_val, // Level the external circuit holds
    output logic [7:0] pin_level // Resolved level back to the pads
);
    logic [7:0] float_q = 8'h55; // Pattern seen on pins nobody holds

    // Floating pins change every cycle so a stale value never passes
    always_ff @(posedge ref_clk)
    begin
        float_q <= ~float_q;
    end

    // Device driver beats the outside source, a weak pull-up beats nothing
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_q[i]; // Undriven pin
        end
    end
endmodule : port_pin_partner

// file: verif/tb_port_with_pin_interrupts.sv
// Self-checking bench for the I/O port with pin interrupts
`timescale 1ns/1ps
module tb_port_with_pin_interrupts;
    import port_irq_pkg::*;
    logic ref_clk, reset, power_on_reset, reg_wr_en, reg_rd_en, analog_cfg_wr; // Core side
    logic clock_out_function, clock_out_level, master_clear_input, pullup_enable_n; // Config
    logic edge_rising, timer_overflow, peripheral_irq, irq_request; // Interrupt side
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, pin_in, pin_out, pin_oe_n, pin_pullup;
    logic [7:0] alt_func_mask, analog_cfg, ext_en, ext_val; // Config and far side
    osc_mode_t osc_mode; // Oscillator mode
    osc_mode_t modes[6] = '{osc_lp, osc_xt, osc_hs, internal_rc_osc_mode, external_rc_osc_mode,
        osc_mode_t'(3'b111)}; // Last entry is an unused code, handled like a crystal
    logic [7:0] m_irq, m_lat, m_ana; // Model: interrupt control, latch, analog pins
    logic [5:0] m_dir; // Model: stored direction bits
    logic [31:0] lfsr_q = 32'h5570_bd72; // Random source
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    port_with_pin_interrupts port_with_pin_interrupts_i (.ref_clk, .reset, .power_on_reset,
        .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .pin_in, .pin_out,
        .pin_oe_n, .pin_pullup, .osc_mode, .clock_out_function, .clock_out_level,
        .master_clear_input, .alt_func_mask, .analog_cfg_wr, .analog_cfg, .pullup_enable_n,
        .edge_rising, .timer_overflow, .peripheral_irq, .irq_request);
    port_pin_partner port_pin_partner_i (.ref_clk, .pin_out, .pin_oe_n, .pin_pullup,
        .ext_en, .ext_val, .pin_level(pin_in));

    // Free-running core clock, 8 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Hang guard; the whole run needs well under this many cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            conclude();
        end
    end

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction : rnd
    function automatic logic rc();
        return osc_mode inside {internal_rc_osc_mode, external_rc_osc_mode};
    endfunction : rc
    // Pins that must read zero on a port read
    function automatic logic [7:0] rz();
        logic [7:0] o;
        o = rc() ? 8'h00 : 8'h30;
        if (osc_mode == external_rc_osc_mode)
            o[5] = 1'b1;
        if (rc() && clock_out_function)
            o[4] = 1'b1;
        return o | alt_func_mask | m_ana | (master_clear_input ? 8'h08 : 8'h00);
    endfunction : rz
    // Direction as read back: pin 3 one, 7:6 zero, 5:4 forced outside RC
    function automatic logic [7:0] dview();
        return {2'b00, rc() ? m_dir[5:4] : 2'b11, 1'b1, m_dir[2:0]};
    endfunction : dview
    function automatic logic [7:0] pu();
        return (pullup_enable_n ? 8'h00 : 8'h0b & ~rz()) | (master_clear_input ? 8'h08 : 8'h00);
    endfunction : pu
    // Port read sees pin levels, never the latch of an undriven pin
    function automatic logic [7:0] port_exp();
        logic [7:0] drv;
        logic [7:0] lvl;
        drv = ~dview();
        lvl = (ext_en & ext_val) | (~ext_en & pu());
        return ((drv & m_lat) | (~drv & lvl)) & ~rz();
    endfunction : port_exp
    function automatic logic req();
        return m_irq[7] & ((|(m_irq[5:3] & m_irq[2:0])) | (m_irq[6] & peripheral_irq));
    endfunction : req

    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : w
    // Register write; the model follows what the write may change
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wr_data = v;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        case (a)
            ADDR_IRQ_CONTROL, ADDR_IRQ_CONTROL_HI: m_irq = v;
            ADDR_PORT_PIN_STATE: m_lat = v;
            ADDR_PORT_DIRECTION:
            begin
                m_dir[2:0] = v[2:0];
                if (rc())
                    m_dir[5] = v[5];
                if (rc() && !clock_out_function)
                    m_dir[4] = v[4];
            end
            default: ;
        endcase
    endtask : wr
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8
    task automatic cmp1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp1
    // Read after two cycles so the pad synchroniser has settled
    task automatic chk(input logic [7:0] a, input string what, input logic [7:0] exp);
        w(2);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        cmp8(what, exp, reg_rd_data);
    endtask : chk
    task automatic ck_irq();
        cmp1("irq_request", req(), irq_request);
        chk(ADDR_IRQ_CONTROL_HI, "irq_control", m_irq);
    endtask : ck_irq
    task automatic ana(input logic [7:0] v);
        @(negedge ref_clk);
        analog_cfg = v;
        analog_cfg_wr = 1'b1;
        m_ana = v & 8'h17;
        @(negedge ref_clk);
        analog_cfg_wr = 1'b0;
    endtask : ana
    task automatic do_reset(input logic por);
        @(negedge ref_clk);
        reset = 1'b1;
        power_on_reset = por;
        w(8);
        reset = 1'b0;
        power_on_reset = 1'b0;
        m_irq = 8'h00;
        m_dir = 6'h3f;
        m_lat = 8'h00;
        if (por)
            m_ana = 8'h17;
    endtask : do_reset
    task automatic conclude();
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        {reset, power_on_reset, reg_wr_en, reg_rd_en, analog_cfg_wr} = 5'b1_1000;
        {clock_out_function, clock_out_level, master_clear_input} = 3'b000;
        {edge_rising, timer_overflow, peripheral_irq, pullup_enable_n} = 4'b0001;
        {reg_addr, reg_wr_data, alt_func_mask, analog_cfg} = 32'h0000_0000;
        {ext_en, ext_val} = 16'hffff;
        osc_mode = internal_rc_osc_mode;
        do_reset(1'b1);
        chk(ADDR_PORT_DIRECTION, "direction", dview());
        ck_irq();
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        ana(8'h00);
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        wr(8'h06, 8'hff);
        chk(8'h06, "unmapped", 8'h00);
        // Every oscillator mode, with zero written to the direction register
        foreach (modes[k])
        begin
            osc_mode = modes[k];
            wr(ADDR_PORT_DIRECTION, 8'h00);
            chk(ADDR_PORT_DIRECTION, "direction", dview());
            chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        end
        // Clock out on pin 4 blocks its direction bit
        osc_mode = internal_rc_osc_mode;
        clock_out_function = 1'b1;
        wr(ADDR_PORT_DIRECTION, 8'h3f);
        for (int k = 0; k < 2; k++)
        begin
            clock_out_level = k[0];
            w(1);
            cmp8("clock_out", {7'b0, k[0]}, {6'b0, pin_oe_n[4], pin_out[4]});
        end
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        clock_out_function = 1'b0;
        chk(ADDR_PORT_DIRECTION, "direction", dview());
        // Alternate pins, master clear and group pull-ups
        alt_func_mask = 8'h21;
        master_clear_input = 1'b1;
        ext_en = 8'hf7;
        w(1);
        cmp8("pin_pullup", pu(), pin_pullup);
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        {alt_func_mask, master_clear_input, pullup_enable_n, ext_en} = {8'h00, 2'b00, 8'hf4};
        w(1);
        cmp8("pin_pullup", pu(), pin_pullup);
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        ext_en = 8'hff;
        // Random direction, latch and pad traffic
        for (int i = 0; i < 40; i++)
        begin
            pullup_enable_n = rnd() > 8'h7f;
            ext_val = rnd();
            wr(ADDR_PORT_DIRECTION, rnd());
            wr(ADDR_PORT_PIN_STATE, rnd());
            cmp8("pin_oe_n", dview(), pin_oe_n);
            cmp8("pin_out", m_lat & ~dview(), pin_out & ~dview());
            cmp8("pin_pullup", pu(), pin_pullup);
            chk(ADDR_PORT_PIN_STATE, "port", port_exp());
            chk(ADDR_PORT_DIRECTION, "direction", dview());
        end
        // Warm reset keeps the analog selection; a high edge pin must not flag
        edge_rising = 1'b1;
        ext_val[2] = 1'b1;
        ana(8'h03);
        do_reset(1'b0);
        chk(ADDR_PORT_DIRECTION, "direction", dview());
        cmp8("pin_oe_n", 8'h3f, pin_oe_n & 8'h3f);
        ck_irq();
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        ana(8'h00);
        // Pin change: set, cleared by software, masked by master clear
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        wr(ADDR_IRQ_CONTROL, 8'h08);
        ext_val[1] = ~ext_val[1];
        w(5);
        m_irq[0] = 1'b1;
        ck_irq();
        chk(ADDR_PORT_PIN_STATE, "port", port_exp());
        wr(ADDR_IRQ_CONTROL, 8'h08);
        ck_irq();
        master_clear_input = 1'b1;
        ext_val[3] = ~ext_val[3];
        w(5);
        ck_irq();
        ext_val[3] = ~ext_val[3];
        w(3);
        master_clear_input = 1'b0;
        wr(ADDR_IRQ_CONTROL, 8'h00);
        ext_val[0] = ~ext_val[0];
        w(5);
        ck_irq();
        // Edge pin, both polarities, wrong edge first
        for (int p = 1; p >= 0; p--)
        begin
            edge_rising = p[0];
            ext_val[2] = p[0];
            w(5);
            wr(ADDR_IRQ_CONTROL, m_irq & 8'hfd);
            ext_val[2] = ~p[0];
            w(5);
            ck_irq();
            ext_val[2] = p[0];
            w(5);
            m_irq[1] = 1'b1;
            ck_irq();
        end
        wr(ADDR_IRQ_CONTROL_HI, 8'h92);
        ck_irq();
        wr(ADDR_IRQ_CONTROL, 8'h12);
        w(20);
        ck_irq();
        // Timer overflow, then peripheral request
        wr(ADDR_IRQ_CONTROL, 8'h00);
        timer_overflow = 1'b1;
        w(1);
        timer_overflow = 1'b0;
        w(2);
        m_irq[2] = 1'b1;
        ck_irq();
        wr(ADDR_IRQ_CONTROL, 8'ha4);
        ck_irq();
        wr(ADDR_IRQ_CONTROL, 8'h24);
        ck_irq();
        peripheral_irq = 1'b1;
        wr(ADDR_IRQ_CONTROL, 8'h80);
        ck_irq();
        wr(ADDR_IRQ_CONTROL, 8'hc0);
        ck_irq();
        peripheral_irq = 1'b0;
        w(1);
        cmp1("irq_request", req(), irq_request);
        conclude();
    end
endmodule : tb_port_with_pin_interrupts
